// [cmp_pkg.sv]
// shared constants and types for the comparator control block
package cmp_pkg;

    // register byte addresses on the bus
    localparam logic [31:0] CTRL_ADDR   = 32'h0000_0f90;
    localparam logic [31:0] AUX_ADDR    = 32'h0000_0f94;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0f98;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h14;
    localparam logic       PWR_DOWN_RESET = 1'b0;
    localparam logic       ROUTE_RESET    = 1'b0;

    // auxiliary control bit positions
    localparam int AUX_PWR_DOWN_BIT = 0;
    localparam int AUX_ROUTE_BIT    = 1;

    // status bit positions
    localparam int ST_RESULT_BIT  = 0;
    localparam int ST_SMALL_BIT   = 1;
    localparam int ST_POWERED_BIT = 2;

    // analog levels are carried as millivolt codes
    localparam int MV_W = 12;
    localparam logic [MV_W-1:0] HYST_MV          = 12'h00a;
    localparam logic [MV_W-1:0] REF_STEP_LARGE_MV = 12'h0c8;
    localparam logic [MV_W-1:0] REF_STEP_SMALL_MV = 12'h032;
    localparam logic [3:0]      LARGE_MAX_CODE    = 4'h9;
    localparam logic [1:0]      LOW_BITS_CLEAR    = 2'h0;

    // bus size encoding and strap fill count
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] STRAP_FILL = 2'h3;

    // control register layout, msb first
    typedef struct packed {
        logic       pos_sel;
        logic       neg_sel;
        logic [5:0] level;
    } comparator_control_t;

    // one register write from the bus slave
    typedef struct packed {
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_write_t;

    typedef enum logic [1:0] {
        S_IDLE    = 2'b00,
        S_WR      = 2'b01,
        S_RD_WAIT = 2'b10,
        S_RD      = 2'b11
    } bus_state_t;

endpackage

// [ahb_reg_slave.sv]
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/100ps
module ahb_reg_slave (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave port
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic                 hready,
    input  wire logic [31:0]          hwdata,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // register side
    output cmp_pkg::reg_write_t       wr,
    output logic [31:0]               rd_addr,
    input  wire logic [31:0]          rd_data
);

    cmp_pkg::bus_state_t state_r;
    cmp_pkg::bus_state_t state_nxt;
    logic [31:0]         addr_r;
    logic [31:0]         addr_nxt;
    logic [31:0]         hrdata_r;
    logic [31:0]         hrdata_nxt;
    logic                accept;

    // only whole-word transfers are taken; others complete as no-ops
    assign accept = hsel & htrans[1] & hready & (hsize == cmp_pkg::HSIZE_WORD);

    // read data is sampled one cycle late so a write just before lands first
    always_comb begin
        state_nxt  = state_r;
        addr_nxt   = addr_r;
        hrdata_nxt = hrdata_r;
        case (state_r)
            cmp_pkg::S_RD_WAIT: begin
                hrdata_nxt = rd_data;
                state_nxt  = cmp_pkg::S_RD;
            end
            default: begin
                if (accept) begin
                    addr_nxt  = haddr;
                    state_nxt = hwrite ? cmp_pkg::S_WR : cmp_pkg::S_RD_WAIT;
                end else begin
                    state_nxt = cmp_pkg::S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r  <= cmp_pkg::S_IDLE;
            addr_r   <= 32'h0000_0000;
            hrdata_r <= 32'h0000_0000;
        end else begin
            state_r  <= state_nxt;
            addr_r   <= addr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // handshake and register strobes
    assign hreadyout = (state_r != cmp_pkg::S_RD_WAIT);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign wr.wr     = (state_r == cmp_pkg::S_WR);
    assign wr.addr   = addr_r;
    assign wr.wdata  = hwdata;
    assign rd_addr   = addr_r;

endmodule

// [hyst_comparator.sv]
// digital model of a comparator stage with hysteresis and change pulse
`timescale 1ns/100ps
module hyst_comparator (
    // clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // power enable and analog levels as millivolt codes
    input  wire logic                      enable,
    input  wire logic [cmp_pkg::MV_W-1:0]  pos_mv,
    input  wire logic [cmp_pkg::MV_W-1:0]  neg_mv,
    // result
    output logic                           result,
    output logic                           change
);

    logic              result_r;
    logic              result_nxt;
    logic              change_r;
    logic              change_nxt;
    logic [cmp_pkg::MV_W:0] pos_w;
    logic [cmp_pkg::MV_W:0] neg_w;
    logic [cmp_pkg::MV_W:0] hyst_w;

    // one extra bit so the sums cannot wrap
    assign pos_w  = {1'b0, pos_mv};
    assign neg_w  = {1'b0, neg_mv};
    assign hyst_w = {1'b0, cmp_pkg::HYST_MV};

    // inside the band the old decision is kept; powered down reads low
    always_comb begin
        result_nxt = result_r;
        if (!enable) begin
            result_nxt = 1'b0;
        end else if (pos_w > neg_w + hyst_w) begin
            result_nxt = 1'b1;
        end else if (neg_w > pos_w + hyst_w) begin
            result_nxt = 1'b0;
        end
        change_nxt = enable & (result_nxt != result_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_r <= 1'b0;
            change_r <= 1'b0;
        end else begin
            result_r <= result_nxt;
            change_r <= change_nxt;
        end
    end

    assign result = result_r;
    assign change = change_r;

endmodule

// [comparator_control_logic.sv]
// comparator control: register file, input selection, reference, output
//
// Functional notes
// - result goes high when positive input beats negative by over hysteresis.
// - result goes low when negative input beats positive by over hysteresis.
// - inside the hysteresis band the result keeps its previous value.
// - result feeds an interrupt request and can be driven to a pin.
// - a power control bit shuts the comparator down.
// - positive select 0 takes the pin, 1 takes the temperature sensor.
// - negative select 0 uses the pin, 1 enables the internal reference.
// - large parts: 4-bit code, 0.2 V steps to code 9, rest reserved.
// - reference code resets to 0101, that is 1.0 V, on large parts.
// - 8-pin parts: 6-bit code, 0.05 V steps, default 010100 is 1.00 V.
// - comparator reference is independent of any converter reference setting.
`timescale 1ns/100ps
module comparator_control_logic (
    // clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // ahb-lite slave port
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    input  wire logic [31:0]               hwdata,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    // package strap pin, high on the 8-pin part
    input  wire logic                      small_package,
    // analog levels as millivolt codes
    input  wire logic [cmp_pkg::MV_W-1:0]  positive_input_pin,
    input  wire logic [cmp_pkg::MV_W-1:0]  negative_input_pin,
    input  wire logic [cmp_pkg::MV_W-1:0]  temp_sensor_mv,
    // comparator result and its routing
    output logic                           result_level,
    output logic                           result_event,
    output logic                           result_pin_out,
    output logic                           result_pin_oe,
    // analog front-end controls
    output logic                           reference_enable,
    output logic [cmp_pkg::MV_W-1:0]       reference_mv,
    output logic                           temp_sensor_select,
    output logic                           comparator_powered
);

    // bus side
    cmp_pkg::reg_write_t wr;
    logic [31:0]         rd_addr;
    logic [31:0]         rd_data;

    // strap capture
    logic [2:0]          strap_sync_r;
    logic [2:0]          strap_sync_nxt;
    logic [1:0]          fill_r;
    logic [1:0]          fill_nxt;
    logic                captured_r;
    logic                captured_nxt;
    logic                small_r;
    logic                small_nxt;

    // software state
    cmp_pkg::comparator_control_t ctrl_r;
    cmp_pkg::comparator_control_t ctrl_nxt;
    logic                power_down_r;
    logic                power_down_nxt;
    logic                route_r;
    logic                route_nxt;
    logic [cmp_pkg::MV_W-1:0] ref_mv_r;
    logic [cmp_pkg::MV_W-1:0] ref_mv_nxt;

    // comparator path
    logic [3:0]          large_code;
    logic [cmp_pkg::MV_W-1:0] cmp_pos;
    logic [cmp_pkg::MV_W-1:0] cmp_neg;
    logic                powered;
    logic                result;
    logic                change;

    ahb_reg_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr        (wr),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data)
    );

    // strap passes three flops and is frozen once the last two agree
    always_comb begin
        strap_sync_nxt = {strap_sync_r[1:0], small_package};
        fill_nxt       = fill_r;
        captured_nxt   = captured_r;
        small_nxt      = small_r;
        if (fill_r != cmp_pkg::STRAP_FILL) begin
            fill_nxt = fill_r + 2'h1;
        end else if (!captured_r && (strap_sync_r[1] == strap_sync_r[2])) begin
            captured_nxt = 1'b1;
            small_nxt    = strap_sync_r[2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_sync_r <= 3'h0;
            fill_r       <= 2'h0;
            captured_r   <= 1'b0;
            small_r      <= 1'b0;
        end else begin
            strap_sync_r <= strap_sync_nxt;
            fill_r       <= fill_nxt;
            captured_r   <= captured_nxt;
            small_r      <= small_nxt;
        end
    end

    // register writes; low level bits exist only on the small part
    always_comb begin
        ctrl_nxt       = ctrl_r;
        power_down_nxt = power_down_r;
        route_nxt      = route_r;
        if (wr.wr && (wr.addr == cmp_pkg::CTRL_ADDR)) begin
            ctrl_nxt = cmp_pkg::comparator_control_t'(wr.wdata[7:0]);
        end
        if (wr.wr && (wr.addr == cmp_pkg::AUX_ADDR)) begin
            power_down_nxt = wr.wdata[cmp_pkg::AUX_PWR_DOWN_BIT];
            route_nxt      = wr.wdata[cmp_pkg::AUX_ROUTE_BIT];
        end
        if (!small_nxt) begin
            ctrl_nxt.level[1:0] = cmp_pkg::LOW_BITS_CLEAR;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r       <= cmp_pkg::CTRL_RESET;
            power_down_r <= cmp_pkg::PWR_DOWN_RESET;
            route_r      <= cmp_pkg::ROUTE_RESET;
        end else begin
            ctrl_r       <= ctrl_nxt;
            power_down_r <= power_down_nxt;
            route_r      <= route_nxt;
        end
    end

    // reference ladder; owns no link to any converter reference
    // reserved large-part codes pin at the top step instead of floating
    assign large_code = (ctrl_r.level[5:2] > cmp_pkg::LARGE_MAX_CODE) ?
                        cmp_pkg::LARGE_MAX_CODE : ctrl_r.level[5:2];

    always_comb begin
        ref_mv_nxt = '0;
        if (ctrl_r.neg_sel) begin
            if (small_r) begin
                ref_mv_nxt = cmp_pkg::MV_W'(ctrl_r.level)
                           * cmp_pkg::REF_STEP_SMALL_MV;
            end else begin
                ref_mv_nxt = cmp_pkg::MV_W'(large_code)
                           * cmp_pkg::REF_STEP_LARGE_MV;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_mv_r <= '0;
        end else begin
            ref_mv_r <= ref_mv_nxt;
        end
    end

    // input selection in front of the comparator stage
    assign cmp_pos = ctrl_r.pos_sel ? temp_sensor_mv
                                    : positive_input_pin;
    assign cmp_neg = ctrl_r.neg_sel ? ref_mv_r
                                    : negative_input_pin;
    assign powered = ~power_down_r;

    hyst_comparator u_cmp (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (powered),
        .pos_mv  (cmp_pos),
        .neg_mv  (cmp_neg),
        .result  (result),
        .change  (change)
    );

    // outputs; the change pulse is the interrupt request source
    // reconfiguring may raise a spurious pulse, software masks it
    assign result_level       = result;
    assign result_event       = change;
    assign result_pin_out     = route_r & result;
    assign result_pin_oe      = route_r;
    assign reference_enable   = ctrl_r.neg_sel & powered;
    assign reference_mv       = ref_mv_r;
    assign temp_sensor_select = ctrl_r.pos_sel;
    assign comparator_powered = powered;

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            cmp_pkg::CTRL_ADDR: begin
                rd_data[7:0] = ctrl_r;
            end
            cmp_pkg::AUX_ADDR: begin
                rd_data[cmp_pkg::AUX_PWR_DOWN_BIT] = power_down_r;
                rd_data[cmp_pkg::AUX_ROUTE_BIT]    = route_r;
            end
            cmp_pkg::STATUS_ADDR: begin
                rd_data[cmp_pkg::ST_RESULT_BIT]  = result;
                rd_data[cmp_pkg::ST_SMALL_BIT]   = small_r;
                rd_data[cmp_pkg::ST_POWERED_BIT] = powered;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // helper: no control write since reset
    logic ctrl_untouched_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_untouched_r <= 1'b1;
        end else if (wr.wr && (wr.addr == cmp_pkg::CTRL_ADDR)) begin
            ctrl_untouched_r <= 1'b0;
        end
    end

    a_high_above:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (powered && ({1'b0, cmp_pos} > {1'b0, cmp_neg} + {1'b0, cmp_pkg::HYST_MV}))
        |=> result_level)
        else $error("result not high above band");

    a_low_below:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (powered && ({1'b0, cmp_neg} > {1'b0, cmp_pos} + {1'b0, cmp_pkg::HYST_MV}))
        |=> !result_level)
        else $error("result not low below band");

    a_hold_band:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (powered
         && ({1'b0, cmp_pos} <= {1'b0, cmp_neg} + {1'b0, cmp_pkg::HYST_MV})
         && ({1'b0, cmp_neg} <= {1'b0, cmp_pos} + {1'b0, cmp_pkg::HYST_MV}))
        |=> $stable(result_level))
        else $error("result moved inside band");

    a_event_edge:
    assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(result_level) && $past(powered) |-> result_event)
        else $error("result change without event");

    a_pin_route:
    assert property (@(posedge hclk) disable iff (!hresetn)
        result_pin_oe |-> (result_pin_out == result_level))
        else $error("routed pin differs from result");

    a_power_down:
    assert property (@(posedge hclk) disable iff (!hresetn)
        !powered |=> !result_level && !result_event)
        else $error("powered-down comparator still active");

    a_pos_sel:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (powered && ctrl_r.pos_sel
         && ({1'b0, temp_sensor_mv} > {1'b0, cmp_neg} + {1'b0, cmp_pkg::HYST_MV}))
        |=> result_level)
        else $error("temperature sensor not selected");

    a_neg_sel:
    assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_r.neg_sel |-> !reference_enable ##1 (reference_mv == '0))
        else $error("reference alive while pin selected");

    a_ref_large:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (!small_r && ctrl_r.neg_sel && ctrl_r.level[5:2] == 4'h5)
        |=> reference_mv == 12'h3e8)
        else $error("large-part reference wrong");

    a_ctrl_reset:
    assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_untouched_r |-> (ctrl_r == cmp_pkg::CTRL_RESET))
        else $error("control reset value lost");

    a_ref_small:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (small_r && ctrl_r.neg_sel && ctrl_r.level == 6'h14 && $stable(ctrl_r))
        |=> reference_mv == 12'h3e8)
        else $error("small-part reference wrong");

    a_low_bits:
    assert property (@(posedge hclk) disable iff (!hresetn)
        !small_r |-> (ctrl_r.level[1:0] == 2'h0))
        else $error("reserved low bits set on large part");

endmodule

// [analog_source.sv]
// stand-in for the external analog levels on the comparator inputs
`timescale 1ns/100ps
module analog_source (
    // levels commanded by the bench
    input  wire logic [cmp_pkg::MV_W-1:0] pos_cmd,
    input  wire logic [cmp_pkg::MV_W-1:0] neg_cmd,
    input  wire logic [cmp_pkg::MV_W-1:0] temp_cmd,
    // levels presented to the block
    output logic [cmp_pkg::MV_W-1:0]      pos_out,
    output logic [cmp_pkg::MV_W-1:0]      neg_out,
    output logic [cmp_pkg::MV_W-1:0]      temp_out
);
    // analog nodes are continuous, so levels pass without delay
    assign pos_out  = pos_cmd;
    assign neg_out  = neg_cmd;
    assign temp_out = temp_cmd;
endmodule

// [comparator_control_logic_test.sv]
// self-checking bench for the comparator control block
`timescale 1ns/100ps
module comparator_control_logic_test;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [11:0] pos;
        logic [11:0] neg;
        logic [11:0] temp;
        logic        res;
        logic        tsel;
        logic        ren;
    } row_t;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        small_package, result_level, result_event, result_pin_out;
    logic        result_pin_oe, reference_enable, temp_sensor_select;
    logic        comparator_powered;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [11:0] pos_cmd, neg_cmd, temp_cmd, pos_mv, neg_mv, temp_mv;
    logic [11:0] reference_mv;
    int          fails, checks_done, cycles;
    row_t        rows [8] = '{
        '{8'h54, 12'h3f3, 12'h000, 12'h000, 1'b1, 1'b0, 1'b1},
        '{8'h54, 12'h3ed, 12'h000, 12'h000, 1'b1, 1'b0, 1'b1},
        '{8'h54, 12'h3dd, 12'h000, 12'h000, 1'b0, 1'b0, 1'b1},
        '{8'h54, 12'h3e3, 12'h000, 12'h000, 1'b0, 1'b0, 1'b1},
        '{8'h00, 12'h258, 12'h1f4, 12'h000, 1'b1, 1'b0, 1'b0},
        '{8'h80, 12'h384, 12'h1f4, 12'h12c, 1'b0, 1'b1, 1'b0},
        '{8'he4, 12'h000, 12'h000, 12'h73a, 1'b1, 1'b1, 1'b1},
        '{8'h68, 12'h6a4, 12'h000, 12'h000, 1'b0, 1'b0, 1'b1}};

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    analog_source src (.pos_cmd(pos_cmd), .neg_cmd(neg_cmd),
        .temp_cmd(temp_cmd), .pos_out(pos_mv), .neg_out(neg_mv),
        .temp_out(temp_mv));

    comparator_control_logic uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .small_package(small_package), .positive_input_pin(pos_mv),
        .negative_input_pin(neg_mv), .temp_sensor_mv(temp_mv),
        .result_level(result_level), .result_event(result_event),
        .result_pin_out(result_pin_out), .result_pin_oe(result_pin_oe),
        .reference_enable(reference_enable), .reference_mv(reference_mv),
        .temp_sensor_select(temp_sensor_select),
        .comparator_powered(comparator_powered));

    // clock at 250 mhz
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // expected reference level, worked out from the level code
    function automatic logic [11:0] exp_ref(input logic [7:0] c,
                                            input logic       sm);
        if (!c[6]) return 12'h000;
        if (sm) return 12'(c[5:0] * cmp_pkg::REF_STEP_SMALL_MV);
        if (c[5:2] > 4'h9) return 12'(9 * cmp_pkg::REF_STEP_LARGE_MV);
        return 12'(c[5:2] * cmp_pkg::REF_STEP_LARGE_MV);
    endfunction

    // ready and read data are taken at the rising edge, as the slave
    // launched them before that edge; the bench timeout ends a hang
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0000_0000;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask

    // reference lags a write by one edge, the result by one more
    task automatic settle();
        repeat (3) @(posedge hclk);
        @(negedge hclk);
    endtask

    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = cmp_pkg::HSIZE_WORD;
        hwdata = 32'h0000_0000;
        small_package = 1'b0;
        pos_cmd = 12'h000;
        neg_cmd = 12'h000;
        temp_cmd = 12'h000;
        hresetn = 1'b0;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        rd(cmp_pkg::CTRL_ADDR, 32'h0000_0014);
        rd(cmp_pkg::AUX_ADDR, 32'h0000_0000);
        rd(cmp_pkg::STATUS_ADDR, 32'h0000_0004);
        // table of input selections and comparisons
        foreach (rows[i]) begin
            @(posedge hclk);
            pos_cmd <= rows[i].pos;
            neg_cmd <= rows[i].neg;
            temp_cmd <= rows[i].temp;
            wr(cmp_pkg::CTRL_ADDR, {24'h000000, rows[i].ctrl});
            settle();
            check(result_level, rows[i].res);
            check(temp_sensor_select, rows[i].tsel);
            check(reference_enable, rows[i].ren);
            check(reference_mv, exp_ref(rows[i].ctrl, 1'b0));
        end
        // every level code, reserved ones included
        for (int c = 0; c < 16; c++) begin
            wr(cmp_pkg::CTRL_ADDR, 32'h0000_0040 | (c << 2));
            settle();
            check(reference_mv, exp_ref(8'(8'h40 | (c << 2)), 1'b0));
        end
        wr(cmp_pkg::CTRL_ADDR, 32'h0000_0057);
        rd(cmp_pkg::CTRL_ADDR, 32'h0000_0054);
        // change pulse on a rising result
        pos_cmd <= 12'h000;
        settle();
        @(posedge hclk);
        pos_cmd <= 12'h3f3;
        @(posedge hclk);
        @(negedge hclk);
        check(result_event, 1'b1);
        check(result_level, 1'b1);
        @(negedge hclk);
        check(result_event, 1'b0);
        // pin routing, then power down and back up
        wr(cmp_pkg::AUX_ADDR, 32'h0000_0002);
        settle();
        check(result_pin_oe, 1'b1);
        check(result_pin_out, 1'b1);
        rd(cmp_pkg::STATUS_ADDR, 32'h0000_0005);
        wr(cmp_pkg::AUX_ADDR, 32'h0000_0003);
        settle();
        check(comparator_powered, 1'b0);
        check(result_level, 1'b0);
        check(reference_enable, 1'b0);
        rd(cmp_pkg::STATUS_ADDR, 32'h0000_0000);
        wr(cmp_pkg::AUX_ADDR, 32'h0000_0000);
        settle();
        check(comparator_powered, 1'b1);
        check(result_level, 1'b1);
        // unmapped place: write ignored, read zero
        wr(32'h0000_0f9c, 32'h0000_00ff);
        rd(32'h0000_0f9c, 32'h0000_0000);
        check(hresp, 1'b0);
        // a byte-sized write is not a whole word and must be ignored
        hsize <= 3'h0;
        wr(cmp_pkg::CTRL_ADDR, 32'h0000_00ff);
        hsize <= cmp_pkg::HSIZE_WORD;
        rd(cmp_pkg::CTRL_ADDR, 32'h0000_0054);
        // second reset as the small package
        @(posedge hclk);
        hresetn <= 1'b0;
        small_package <= 1'b1;
        pos_cmd <= 12'h000;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        rd(cmp_pkg::CTRL_ADDR, 32'h0000_0014);
        rd(cmp_pkg::STATUS_ADDR, 32'h0000_0006);
        wr(cmp_pkg::CTRL_ADDR, 32'h0000_0057);
        rd(cmp_pkg::CTRL_ADDR, 32'h0000_0057);
        settle();
        check(reference_mv, exp_ref(8'h57, 1'b1));
        // default six-bit code selects one volt on the small part
        wr(cmp_pkg::CTRL_ADDR, 32'h0000_0054);
        settle();
        check(reference_mv, 12'h3e8);
        conclude();
    end
endmodule
